// [inc/plps_pkg.sv]
package plps_pkg;

  // timing
  localparam int CLK_PERIOD_PSEC = 5000;
  localparam int SAVE_RELEASE_NS = 1000;
  localparam int WAKE_WINDOW_NS = 2000;
  localparam int WAKE_PULSE_NS = 20;
  localparam int LOCK_QUIET_NS = 500;
  localparam int WAKE_WINDOW_CYC = (WAKE_WINDOW_NS * 1000) / CLK_PERIOD_PSEC;
  localparam int WAKE_PULSE_CYC = (WAKE_PULSE_NS * 1000) / CLK_PERIOD_PSEC;
  localparam int LOCK_QUIET_CYC =
    (LOCK_QUIET_NS * 1000 + CLK_PERIOD_PSEC - 1) / CLK_PERIOD_PSEC;

  // serial word layout
  localparam int SHIFT_W = 19;
  localparam int REF_W = 17;
  localparam int DIV_W = 18;
  localparam int REF_RATIO_LSB = 0;
  localparam int REF_PRESCALE_BIT = 14;
  localparam int REF_POL_BIT = 15;
  localparam int REF_MON_BIT = 16;
  localparam int DIV_SWALLOW_LSB = 0;
  localparam int DIV_COUNT_LSB = 7;

  // register map
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_REF = 8'h04;
  localparam logic [7:0] ADDR_DIV = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0c;
  localparam int CTRL_POL_BIT = 0;
  localparam int CTRL_MON_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam int STAT_SAVE_BIT = 0;
  localparam int STAT_LOCK_BIT = 1;
  localparam int STAT_WAKE_BIT = 2;
  localparam int STAT_UP_BIT = 3;
  localparam int STAT_DN_BIT = 4;

  typedef enum logic [1:0]
  {
    PWR_SAVE = 2'b00,
    PWR_WAKE = 2'b01,
    PWR_RUN = 2'b11
  } plps_pwr_e;

  typedef struct packed
  {
    logic [REF_W-1:0] refWord;
    logic [DIV_W-1:0] divWord;
    logic refLoad;
  } plps_latch_s;

endpackage

// [rtl/plps_serial.sv]
`timescale 1ns/1ps

module plps_serial
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic serialClock,
  input wire logic serialData,
  input wire logic loadEnable,
  output plps_pkg::plps_latch_s latch
);

  logic [plps_pkg::SHIFT_W-1:0] shift_q;
  logic sclkPrev_q;
  plps_pkg::plps_latch_s latch_q;
  wire sclkRise = serialClock & ~sclkPrev_q;
  wire loadRef = loadEnable & shift_q[0];
  wire loadDiv = loadEnable & ~shift_q[0];

  assign latch = latch_q;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      shift_q <= '0;
      sclkPrev_q <= 1'b0;
    end
    else
    begin
      sclkPrev_q <= serialClock;
      if (sclkRise)
        shift_q <= {shift_q[plps_pkg::SHIFT_W-2:0], serialData};
    end
  end

  // last bit shifted in steers the word to one latch
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      latch_q <= '0;
    else
    begin
      latch_q.refLoad <= loadRef;
      if (loadRef)
        latch_q.refWord <= shift_q[plps_pkg::REF_W:1];
      if (loadDiv)
        latch_q.divWord <= shift_q[plps_pkg::DIV_W:1];
    end
  end

  property p_shift_in;
    @(posedge clk) disable iff (!rstn)
    (serialClock && !sclkPrev_q) |=>
      shift_q == {$past(shift_q[plps_pkg::SHIFT_W-2:0]), $past(serialData)};
  endproperty
  a_shift_in: assert property (p_shift_in)
    else $error("serial bit not shifted on clock rise");

endmodule

// [rtl/plps_top.sv]
// Contract
// - polarity bit inverts pump and comparator outputs
// - polarity high: ref faster drives pump high
// - polarity low: ref faster drives pump low
// - monitor shows reference or comparison by polarity
// - low power-save input enters saving mode
// - wake-up limits phase detector error pulses
// - saving mode floats pump, shows locked
// - serial loading works during saving mode
// - one serial bit per serial clock rise
// - low tristate control floats the pump
// - monitor select low outputs lock indicator
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/1ps

module plps_top
#(
  parameter int WAKE_WINDOW_CYC = plps_pkg::WAKE_WINDOW_CYC,
  parameter int WAKE_PULSE_CYC = plps_pkg::WAKE_PULSE_CYC,
  parameter int LOCK_QUIET_CYC = plps_pkg::LOCK_QUIET_CYC
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic referenceFrequency,
  input wire logic comparisonFrequency,
  input wire logic powerSaveControl,
  input wire logic pumpTristateControl,
  input wire logic serialClock,
  input wire logic serialData,
  input wire logic loadEnable,
  output logic pumpOut,
  output logic pumpOe,
  output logic phiROut,
  output logic phiPOut,
  output logic phiPOe,
  output logic lockMonitor
);

  localparam int WW = $clog2(WAKE_WINDOW_CYC + 1);
  localparam int PW = $clog2(WAKE_PULSE_CYC + 1);
  localparam int LW = $clog2(LOCK_QUIET_CYC + 1);

  ////////////////////////////////////////////////////////////////////////////
  // serial programming, free running in every power state

  plps_pkg::plps_latch_s latch;

  plps_serial u_serial
  (
    .clk(clk),
    .rstn(rstn),
    .serialClock(serialClock),
    .serialData(serialData),
    .loadEnable(loadEnable),
    .latch(latch)
  );

  ////////////////////////////////////////////////////////////////////////////
  // apb slave

  logic [1:0] ctrl_q;
  logic [1:0] ctrl_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pready_q;
  logic pslverr_q;
  logic pslverr_d;

  wire access = psel & penable;
  wire hitCtrl = paddr == plps_pkg::ADDR_CTRL;
  wire hitRef = paddr == plps_pkg::ADDR_REF;
  wire hitDiv = paddr == plps_pkg::ADDR_DIV;
  wire hitStat = paddr == plps_pkg::ADDR_STAT;
  wire mapped = hitCtrl | hitRef | hitDiv | hitStat;
  wire ctrlWrite = access & pready_q & pwrite & hitCtrl;
  wire polSel = ctrl_q[plps_pkg::CTRL_POL_BIT];
  wire monSel = ctrl_q[plps_pkg::CTRL_MON_BIT];

  logic [4:0] status;
  logic [31:0] readMux;

  assign readMux =
    hitCtrl ? {30'h0, ctrl_q} :
    hitRef ? {15'h0, latch.refWord} :
    hitDiv ? {14'h0, latch.divWord} :
    hitStat ? {27'h0, status} : 32'h0;

  // serial load wins over a bus write in the same cycle
  assign ctrl_d =
    latch.refLoad ? {latch.refWord[plps_pkg::REF_MON_BIT],
                     latch.refWord[plps_pkg::REF_POL_BIT]} :
    ctrlWrite ? pwdata[1:0] : ctrl_q;
  assign prdata_d = (access & ~pready_q) ? readMux : prdata_q;
  assign pslverr_d = access & ~pready_q & ~mapped;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_q <= plps_pkg::CTRL_RESET;
      prdata_q <= 32'h0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      prdata_q <= prdata_d;
      pready_q <= access & ~pready_q;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  ////////////////////////////////////////////////////////////////////////////
  // power state

  plps_pkg::plps_pwr_e state_q;
  plps_pkg::plps_pwr_e state_d;
  logic [WW-1:0] wakeCnt_q;
  wire wakeDone = wakeCnt_q == WW'(WAKE_WINDOW_CYC);

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      plps_pkg::PWR_SAVE:
        if (powerSaveControl)
          state_d = plps_pkg::PWR_WAKE;
      plps_pkg::PWR_WAKE:
        if (!powerSaveControl)
          state_d = plps_pkg::PWR_SAVE;
        else if (wakeDone)
          state_d = plps_pkg::PWR_RUN;
      plps_pkg::PWR_RUN:
        if (!powerSaveControl)
          state_d = plps_pkg::PWR_SAVE;
      default:
        state_d = plps_pkg::PWR_SAVE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_q <= plps_pkg::PWR_SAVE;
      wakeCnt_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      if (state_q != plps_pkg::PWR_WAKE)
        wakeCnt_q <= '0;
      else if (!wakeDone)
        wakeCnt_q <= wakeCnt_q + WW'(1);
    end
  end

  wire saving = state_q == plps_pkg::PWR_SAVE;

  ////////////////////////////////////////////////////////////////////////////
  // phase frequency detector

  logic refPrev_q;
  logic cmpPrev_q;
  logic up_q;
  logic dn_q;
  logic [PW-1:0] pulseCnt_q;
  logic [LW-1:0] quietCnt_q;

  wire refRise = referenceFrequency & ~refPrev_q;
  wire cmpRise = comparisonFrequency & ~cmpPrev_q;
  wire upSet = up_q | refRise;
  wire dnSet = dn_q | cmpRise;
  wire active = up_q | dn_q;
  wire pulseFull = pulseCnt_q >= PW'(WAKE_PULSE_CYC);
  wire limit = (state_q == plps_pkg::PWR_WAKE) & pulseFull;
  wire locked = quietCnt_q == LW'(LOCK_QUIET_CYC);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      refPrev_q <= 1'b0;
      cmpPrev_q <= 1'b0;
      up_q <= 1'b0;
      dn_q <= 1'b0;
      pulseCnt_q <= '0;
      quietCnt_q <= '0;
    end
    else
    begin
      refPrev_q <= referenceFrequency;
      cmpPrev_q <= comparisonFrequency;
      up_q <= ~saving & upSet & ~dnSet;
      dn_q <= ~saving & dnSet & ~upSet;
      if (!active)
        pulseCnt_q <= '0;
      else if (!pulseFull)
        pulseCnt_q <= pulseCnt_q + PW'(1);
      if (active)
        quietCnt_q <= '0;
      else if (!locked)
        quietCnt_q <= quietCnt_q + LW'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output drivers

  // lead means pump high, lag means pump low, swapped by polarity
  wire lead = (polSel ? up_q : dn_q) & ~limit;
  wire lag = (polSel ? dn_q : up_q) & ~limit;
  wire pumpDrive = ~saving & pumpTristateControl & (lead | lag);
  wire lockShown = saving | locked;
  wire monD = monSel ? (polSel ? referenceFrequency : comparisonFrequency)
                     : lockShown;

  logic pumpOut_q;
  logic pumpOe_q;
  logic phiR_q;
  logic phiPOe_q;
  logic mon_q;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pumpOut_q <= 1'b0;
      pumpOe_q <= 1'b0;
      phiR_q <= 1'b0;
      phiPOe_q <= 1'b0;
      mon_q <= 1'b1;
    end
    else
    begin
      pumpOut_q <= lead;
      pumpOe_q <= pumpDrive;
      phiR_q <= ~saving & lag & ~lead;
      phiPOe_q <= ~saving & lead;
      mon_q <= monD;
    end
  end

  assign pumpOut = pumpOut_q;
  assign pumpOe = pumpOe_q;
  assign phiROut = phiR_q;
  assign phiPOut = 1'b0;
  assign phiPOe = phiPOe_q;
  assign lockMonitor = mon_q;

  assign status = {dn_q, up_q, state_q == plps_pkg::PWR_WAKE, lockShown,
                   saving};

  ////////////////////////////////////////////////////////////////////////////
  // checks

  wire runOk = ~saving & ~limit & pumpTristateControl;

  property p_enter_save;
    @(posedge clk) disable iff (!rstn)
    !powerSaveControl |=> state_q == plps_pkg::PWR_SAVE;
  endproperty
  a_enter_save: assert property (p_enter_save)
    else $error("power save not entered");
  property p_wake_limit;
    @(posedge clk) disable iff (!rstn)
    (state_q == plps_pkg::PWR_WAKE && pulseCnt_q >= PW'(WAKE_PULSE_CYC))
      |=> !pumpOe;
  endproperty
  a_wake_limit: assert property (p_wake_limit)
    else $error("pump pulse not limited during wake");
  property p_save_outputs;
    @(posedge clk) disable iff (!rstn)
    (saving && !monSel) |=> !pumpOe && lockMonitor;
  endproperty
  a_save_outputs: assert property (p_save_outputs)
    else $error("saving mode pump or lock wrong");
  property p_save_load;
    @(posedge clk) disable iff (!rstn)
    (saving && latch.refLoad) |=>
      ctrl_q[0] == $past(latch.refWord[plps_pkg::REF_POL_BIT]);
  endproperty
  a_save_load: assert property (p_save_load)
    else $error("serial load lost in saving mode");
  property p_tristate;
    @(posedge clk) disable iff (!rstn)
    !pumpTristateControl |=> !pumpOe;
  endproperty
  a_tristate: assert property (p_tristate)
    else $error("pump driven while tristate forced");
  property p_pol_high;
    @(posedge clk) disable iff (!rstn)
    (runOk && polSel && up_q) |=> pumpOe && pumpOut && !phiROut && phiPOe;
  endproperty
  a_pol_high: assert property (p_pol_high)
    else $error("polarity high lead outputs wrong");
  property p_pol_low;
    @(posedge clk) disable iff (!rstn)
    (runOk && !polSel && up_q) |=> pumpOe && !pumpOut && phiROut && !phiPOe;
  endproperty
  a_pol_low: assert property (p_pol_low)
    else $error("polarity low lead outputs wrong");
  property p_equal;
    @(posedge clk) disable iff (!rstn)
    (!up_q && !dn_q) |=> !pumpOe && !phiROut && !phiPOe;
  endproperty
  a_equal: assert property (p_equal)
    else $error("equal phase outputs not idle");
  property p_monitor;
    @(posedge clk) disable iff (!rstn)
    monSel |=> lockMonitor == $past(polSel ? referenceFrequency
                                           : comparisonFrequency);
  endproperty
  a_monitor: assert property (p_monitor)
    else $error("monitor frequency wrong");
  property p_lock_pin;
    @(posedge clk) disable iff (!rstn)
    (!monSel && !saving) |=> lockMonitor == $past(locked);
  endproperty
  a_lock_pin: assert property (p_lock_pin)
    else $error("lock indicator wrong");

endmodule

// [dv/plps_prog.sv]
`timescale 1ns/1ps

module plps_prog
(
  input wire logic clk,
  output logic serialClock,
  output logic serialData,
  output logic loadEnable,
  output logic powerSaveControl
);
  initial
  begin
    serialClock = 1'b0;
    serialData = 1'b0;
    loadEnable = 1'b0;
    powerSaveControl = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial word, msb first, clock idle low between frames
  task automatic send(input logic [18:0] w);
    for (int i = 18; i >= 0; i--)
    begin
      @(posedge clk) serialClock <= 1'b0;
      serialData <= w[i];
      @(posedge clk) serialClock <= 1'b1;
    end
    @(posedge clk) serialClock <= 1'b0;
    serialData <= ~w[0];
    loadEnable <= 1'b1;
    @(posedge clk) loadEnable <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // release only after the supply settle time
  task automatic power(input logic on);
    if (on)
      repeat (plps_pkg::SAVE_RELEASE_NS * 1000 / plps_pkg::CLK_PERIOD_PSEC)
        @(posedge clk);
    @(posedge clk) powerSaveControl <= on;
  endtask
endmodule

// [dv/tb.sv]
`timescale 1ns/1ps

module tb;
  logic clk;
  logic rstn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic referenceFrequency;
  logic comparisonFrequency;
  logic pumpTristateControl;
  logic serialClock, serialData, loadEnable, powerSaveControl;
  logic pumpOut, pumpOe, phiROut, phiPOut, phiPOe, lockMonitor;
  logic [31:0] rd;
  logic err;
  int mismatches;
  int cmp_count;

  plps_top #(.WAKE_WINDOW_CYC(8), .WAKE_PULSE_CYC(2), .LOCK_QUIET_CYC(4))
  u_dut
  (
    .clk(clk),
    .rstn(rstn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .referenceFrequency(referenceFrequency),
    .comparisonFrequency(comparisonFrequency),
    .powerSaveControl(powerSaveControl),
    .pumpTristateControl(pumpTristateControl),
    .serialClock(serialClock),
    .serialData(serialData),
    .loadEnable(loadEnable),
    .pumpOut(pumpOut),
    .pumpOe(pumpOe),
    .phiROut(phiROut),
    .phiPOut(phiPOut),
    .phiPOe(phiPOe),
    .lockMonitor(lockMonitor)
  );

  plps_prog u_prog
  (
    .clk(clk),
    .serialClock(serialClock),
    .serialData(serialData),
    .loadEnable(loadEnable),
    .powerSaveControl(powerSaveControl)
  );

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    if (mismatches == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    cmp_count++;
    if (g !== x)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h exp %h", $time, g, x);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
      mismatches++;
      $display("unexpected at %0t: no pready", $time);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic pin(input logic r, input logic c, input int n);
    @(posedge clk);
    referenceFrequency <= r;
    comparisonFrequency <= c;
    repeat (n) @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk(pumpOe, 1'b0);
    chk(lockMonitor, 1'b1);
    apb(1'b0, plps_pkg::ADDR_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, plps_pkg::ADDR_STAT, 32'h0);
    chk(rd[plps_pkg::STAT_SAVE_BIT], 1'b1);
    apb(1'b1, 8'h40, 32'h3);
    chk(rd, 32'h0);
    chk(err, 1'b1);
  endtask

  task automatic t_serial;
    u_prog.send({1'b0, 17'h0c005, 1'b1});
    apb(1'b0, plps_pkg::ADDR_REF, 32'h0);
    chk(rd, 32'h0000c005);
    apb(1'b0, plps_pkg::ADDR_CTRL, 32'h0);
    chk(rd, 32'h1);
    u_prog.send({18'h00285, 1'b0});
    apb(1'b0, plps_pkg::ADDR_DIV, 32'h0);
    chk(rd, 32'h00000285);
  endtask

  task automatic t_pfd;
    logic e;
    u_prog.power(1'b1);
    repeat (12) @(posedge clk);
    for (int i = 0; i < 4; i++)
    begin
      e = i[0] ~^ i[1];
      apb(1'b1, plps_pkg::ADDR_CTRL, {31'h0, i[1]});
      pin(i[0], ~i[0], 4);
      chk(pumpOe, 1'b1);
      chk({pumpOut, phiROut, phiPOe}, {e, ~e, e});
      chk(phiPOut, 1'b0);
      chk(lockMonitor, 1'b0);
      pin(1'b1, 1'b1, 8);
      chk({pumpOe, phiROut, phiPOe}, 3'b000);
      chk(lockMonitor, 1'b1);
      pin(1'b0, 1'b0, 2);
    end
  endtask

  task automatic t_tristate(input logic z);
    pumpTristateControl <= z;
    pin(1'b1, 1'b0, 4);
    chk(pumpOe, 1'b0);
    pin(1'b1, 1'b1, 2);
    pin(1'b0, 1'b0, 8);
    pumpTristateControl <= ~z;
  endtask

  task automatic t_monitor;
    apb(1'b1, plps_pkg::ADDR_CTRL, 32'h3);
    pin(1'b1, 1'b0, 4);
    chk(lockMonitor, 1'b1);
    pin(1'b0, 1'b0, 4);
    chk(lockMonitor, 1'b0);
    apb(1'b1, plps_pkg::ADDR_CTRL, 32'h2);
    pin(1'b0, 1'b1, 4);
    chk(lockMonitor, 1'b1);
    pin(1'b0, 1'b0, 4);
    chk(lockMonitor, 1'b0);
    pin(1'b1, 1'b0, 2);
    pin(1'b0, 1'b0, 8);
    apb(1'b1, plps_pkg::ADDR_CTRL, 32'h1);
  endtask

  task automatic t_save;
    u_prog.power(1'b0);
    pin(1'b1, 1'b0, 4);
    chk({pumpOe, lockMonitor}, 2'b01);
    apb(1'b0, plps_pkg::ADDR_STAT, 32'h0);
    chk(rd[plps_pkg::STAT_SAVE_BIT], 1'b1);
    pin(1'b0, 1'b0, 2);
    u_prog.power(1'b1);
    pin(1'b1, 1'b0, 7);
    chk(pumpOe, 1'b0);
    pin(1'b1, 1'b1, 4);
    pin(1'b0, 1'b0, 10);
    apb(1'b0, plps_pkg::ADDR_STAT, 32'h0);
    chk(rd[plps_pkg::STAT_SAVE_BIT], 1'b0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #50000;
    mismatches++;
    stop_test();
  end

  initial
  begin
    mismatches = 0;
    cmp_count = 0;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    referenceFrequency = 1'b0;
    comparisonFrequency = 1'b0;
    pumpTristateControl = 1'b1;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_serial();
    t_pfd();
    t_tristate(1'b0);
    t_monitor();
    t_save();
    stop_test();
  end
endmodule
